/* src/dds_pkg.sv */
package dds_pkg;
	// ----------------------------------------------------------------
	// address layout
	// ----------------------------------------------------------------
	localparam int EA_W = 16;
	localparam int DATA_W = 16;
	localparam int EA_TOP_BIT = 15;
	// implemented data memory, in bytes
	localparam int IMPL_BYTES = 1024;
	// fixed x/y boundary, byte address where y starts
	localparam logic [15:0] XY_BOUNDARY = 16'h0200;
	localparam logic [15:0] MEM_BASE = 16'h0000;
	localparam logic [15:0] ZERO_WORD = 16'h0000;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// ----------------------------------------------------------------
	// addressing modes of the address units
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DDS_MODE_LINEAR = 2'h0,
		DDS_MODE_MODULO = 2'h1,
		DDS_MODE_BITREV = 2'h2
	} dds_mode_t;
endpackage : dds_pkg

/* src/dds_agu.sv */
`timescale 1ns/1ps
// address generation unit: modulo wrap and optional bit reversal
module dds_agu #(
	parameter int EA_W = dds_pkg::EA_W,
	parameter bit ALLOW_BITREV = 1'b0
) (
	input wire logic [EA_W-1:0] base_i,
	input wire logic [EA_W-1:0] offset_i,
	input wire dds_pkg::dds_mode_t mode_i,
	input wire logic [EA_W-1:0] mod_start_i,
	input wire logic [EA_W-1:0] mod_end_i,
	input wire logic [EA_W-1:0] rev_mask_i,
	output logic [EA_W-1:0] ea_o
);
	initial
	begin
		if (EA_W != dds_pkg::EA_W)
			$error("dds_agu: address width must be 16");
	end

	logic [EA_W-1:0] sum;
	logic [EA_W-1:0] span;
	logic [EA_W-1:0] rev;
	logic [EA_W-1:0] pre;

	always_comb
	begin
		sum = base_i + offset_i;
		span = mod_end_i - mod_start_i + {{(EA_W-1){1'b0}}, 1'b1};
		pre = base_i;
		// reverse carry addition on masked bits, byte lsb kept
		rev = base_i;
		for (int i = EA_W - 1; i >= 1; i--)
		begin
			if (rev_mask_i[i])
			begin
				rev[i] = ~pre[i];
				if (pre[i] == 1'b0)
					break;
			end
		end
		ea_o = sum;
		unique case (mode_i)
			dds_pkg::DDS_MODE_LINEAR:
				ea_o = sum;
			// circular buffer wrap on both sides
			dds_pkg::DDS_MODE_MODULO:
			begin
				if (sum > mod_end_i)
					ea_o = sum - span;
				else if (sum < mod_start_i)
					ea_o = sum + span;
				else
					ea_o = sum;
			end
			dds_pkg::DDS_MODE_BITREV:
				ea_o = ALLOW_BITREV ? rev : sum;
			default:
				ea_o = sum;
		endcase
	end
endmodule : dds_agu

/* src/dds_bank.sv */
`timescale 1ns/1ps
// flip-flop data ram, one write port, two read ports
module dds_bank #(
	parameter int WORDS = dds_pkg::IMPL_BYTES / 2,
	parameter int DATA_W = dds_pkg::DATA_W,
	parameter int IDX_W = $clog2(WORDS)
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic we_i,
	input wire logic [1:0] be_i,
	input wire logic [IDX_W-1:0] widx_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic [IDX_W-1:0] xidx_i,
	input wire logic [IDX_W-1:0] yidx_i,
	output logic [DATA_W-1:0] xdata_o,
	output logic [DATA_W-1:0] ydata_o
);
	initial
	begin
		if (DATA_W != 16 || WORDS < 2)
			$error("dds_bank: unsupported geometry");
	end

	logic [WORDS-1:0][DATA_W-1:0] mem_q;

	genvar g;
	generate
		for (g = 0; g < WORDS; g++)
		begin : g_word
			always_ff @(posedge mclk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
					mem_q[g] <= dds_pkg::ZERO_WORD;
				else if (we_i && widx_i == IDX_W'(g))
				begin
					if (be_i[0])
						mem_q[g][7:0] <= wdata_i[7:0];
					if (be_i[1])
						mem_q[g][15:8] <= wdata_i[15:8];
				end
			end
		end
	endgenerate

	// both ports independent, same word is fine
	assign xdata_o = mem_q[xidx_i];
	assign ydata_o = mem_q[yidx_i];
endmodule : dds_bank

/* src/dds_access.sv */
`timescale 1ns/1ps
module dds_access #(
	parameter int IMPL_BYTES = dds_pkg::IMPL_BYTES
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// x / unified read request
	input wire logic xrd_en_i,
	input wire logic xrd_byte_i,
	input wire logic xrd_dual_i,
	input wire logic [15:0] xrd_base_i,
	input wire logic [15:0] xrd_off_i,
	input wire dds_pkg::dds_mode_t xrd_mode_i,
	// y read request, dual operand ops only
	input wire logic yrd_en_i,
	input wire logic [15:0] yrd_base_i,
	input wire logic [15:0] yrd_off_i,
	input wire dds_pkg::dds_mode_t yrd_mode_i,
	// write request, unified space
	input wire logic wr_en_i,
	input wire logic wr_byte_i,
	input wire logic [15:0] wr_base_i,
	input wire logic [15:0] wr_off_i,
	input wire dds_pkg::dds_mode_t wr_mode_i,
	input wire logic [15:0] wr_data_i,
	// modulo and bit-reverse setup
	input wire logic [15:0] xmod_start_i,
	input wire logic [15:0] xmod_end_i,
	input wire logic [15:0] ymod_start_i,
	input wire logic [15:0] ymod_end_i,
	input wire logic [15:0] rev_mask_i,
	// answers
	output logic [15:0] xrd_data_o,
	output logic xrd_valid_o,
	output logic [15:0] xrd_ea_o,
	output logic xrd_psv_o,
	output logic [15:0] yrd_data_o,
	output logic yrd_valid_o,
	output logic [15:0] yrd_ea_o,
	output logic yrd_err_o,
	output logic [15:0] wr_ea_o,
	output logic wr_done_o,
	output logic wr_psv_o
);
	localparam int WORDS = IMPL_BYTES / 2;
	localparam int IDX_W = $clog2(WORDS);
	localparam logic [15:0] IMPL_LIMIT = 16'(IMPL_BYTES);

	initial
	begin
		if (IMPL_BYTES < 4 || IMPL_BYTES > 32768 || (IMPL_BYTES % 2) != 0)
			$error("dds_access: implemented size out of range");
		if (dds_pkg::XY_BOUNDARY >= IMPL_LIMIT)
			$error("dds_access: x/y boundary outside memory");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] xrd_data;
		logic xrd_valid;
		logic [15:0] xrd_ea;
		logic xrd_psv;
		logic [15:0] yrd_data;
		logic yrd_valid;
		logic [15:0] yrd_ea;
		logic yrd_err;
		logic [15:0] wr_ea;
		logic wr_done;
		logic wr_psv;
	} dds_state_t;

	dds_state_t st_q;
	dds_state_t st_d;

	// ----------------------------------------------------------------
	// address units
	// ----------------------------------------------------------------
	logic [15:0] xrd_ea;
	logic [15:0] yrd_ea;
	logic [15:0] wr_ea_raw;
	logic [15:0] wr_ea_lin;
	logic [15:0] wr_ea;

	dds_agu #(
		.EA_W(dds_pkg::EA_W),
		.ALLOW_BITREV(1'b0)
	) u_agu_x (
		.base_i(xrd_base_i),
		.offset_i(xrd_off_i),
		.mode_i(xrd_mode_i),
		.mod_start_i(xmod_start_i),
		.mod_end_i(xmod_end_i),
		.rev_mask_i(rev_mask_i),
		.ea_o(xrd_ea)
	);

	// y unit has its own modulo window
	dds_agu #(
		.EA_W(dds_pkg::EA_W),
		.ALLOW_BITREV(1'b0)
	) u_agu_y (
		.base_i(yrd_base_i),
		.offset_i(yrd_off_i),
		.mode_i(yrd_mode_i),
		.mod_start_i(ymod_start_i),
		.mod_end_i(ymod_end_i),
		.rev_mask_i(rev_mask_i),
		.ea_o(yrd_ea)
	);

	dds_agu #(
		.EA_W(dds_pkg::EA_W),
		.ALLOW_BITREV(1'b1)
	) u_agu_w (
		.base_i(wr_base_i),
		.offset_i(wr_off_i),
		.mode_i(wr_mode_i),
		.mod_start_i(xmod_start_i),
		.mod_end_i(xmod_end_i),
		.rev_mask_i(rev_mask_i),
		.ea_o(wr_ea_raw)
	);

	// linear write address, for the y-space fallback
	dds_agu #(
		.EA_W(dds_pkg::EA_W),
		.ALLOW_BITREV(1'b0)
	) u_agu_wl (
		.base_i(wr_base_i),
		.offset_i(wr_off_i),
		.mode_i(wr_mode_i == dds_pkg::DDS_MODE_BITREV ?
			dds_pkg::DDS_MODE_LINEAR : wr_mode_i),
		.mod_start_i(xmod_start_i),
		.mod_end_i(xmod_end_i),
		.rev_mask_i(rev_mask_i),
		.ea_o(wr_ea_lin)
	);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic wr_in_x;
	logic wr_mem;
	logic x_mem;
	logic y_mem;
	logic y_in_y;
	logic [1:0] wr_be;
	logic [15:0] wr_lane;
	logic [15:0] xword;
	logic [15:0] yword;

	always_comb
	begin
		// reversal kept only when it lands in x
		wr_in_x = wr_ea_raw < dds_pkg::XY_BOUNDARY;
		wr_ea = (wr_mode_i == dds_pkg::DDS_MODE_BITREV && !wr_in_x) ?
			wr_ea_lin : wr_ea_raw;
		// writes use the one combined space
		// top bit set goes to program window
		wr_mem = !wr_ea[dds_pkg::EA_TOP_BIT] && wr_ea < IMPL_LIMIT;
		x_mem = !xrd_ea[dds_pkg::EA_TOP_BIT] && xrd_ea < IMPL_LIMIT;
		// fixed boundary splits y from x
		y_in_y = yrd_ea >= dds_pkg::XY_BOUNDARY && yrd_ea < IMPL_LIMIT;
		y_mem = y_in_y && !yrd_ea[dds_pkg::EA_TOP_BIT];
		// even byte is the low lane
		if (wr_byte_i)
		begin
			wr_be = wr_ea[0] ? 2'h2 : 2'h1;
			wr_lane = {wr_data_i[7:0], wr_data_i[7:0]};
		end
		else
		begin
			wr_be = 2'h3;
			wr_lane = wr_data_i;
		end
	end

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	// write bus and read buses kept apart
	dds_bank #(
		.WORDS(WORDS),
		.DATA_W(dds_pkg::DATA_W),
		.IDX_W(IDX_W)
	) u_bank (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.we_i(wr_en_i && wr_mem),
		.be_i(wr_be),
		.widx_i(wr_ea[IDX_W:1]),
		.wdata_i(wr_lane),
		.xidx_i(xrd_ea[IDX_W:1]),
		.yidx_i(yrd_ea[IDX_W:1]),
		.xdata_o(xword),
		.ydata_o(yword)
	);

	// ----------------------------------------------------------------
	// answers
	// ----------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		st_d.xrd_valid = 1'b0;
		st_d.yrd_valid = 1'b0;
		st_d.wr_done = 1'b0;
		// unified and x prefetch reads share one bus
		// x read serves any instruction, any mode, bit-reverse mode read as linear
		if (xrd_en_i)
		begin
			st_d.xrd_valid = 1'b1;
			st_d.xrd_ea = xrd_ea;
			st_d.xrd_psv = xrd_ea[dds_pkg::EA_TOP_BIT];
			if (!x_mem)
				st_d.xrd_data = dds_pkg::ZERO_WORD;
			else if (xrd_byte_i)
				st_d.xrd_data = {dds_pkg::ZERO_BYTE,
					xrd_ea[0] ? xword[15:8] : xword[7:0]};
			else
				st_d.xrd_data = xword;
		end
		// y read only with a dual operand x read
		// dual ops see y as its own space
		// same word yields same data, same cycle, when x reads a whole word
		if (yrd_en_i && xrd_en_i && xrd_dual_i)
		begin
			st_d.yrd_valid = 1'b1;
			st_d.yrd_ea = yrd_ea;
			st_d.yrd_err = !y_in_y;
			st_d.yrd_data = y_mem ? yword : dds_pkg::ZERO_WORD;
		end
		else if (yrd_en_i)
		begin
			st_d.yrd_valid = 1'b1;
			st_d.yrd_ea = yrd_ea;
			st_d.yrd_err = 1'b1;
			st_d.yrd_data = dds_pkg::ZERO_WORD;
		end
		if (wr_en_i)
		begin
			st_d.wr_done = 1'b1;
			st_d.wr_ea = wr_ea;
			st_d.wr_psv = wr_ea[dds_pkg::EA_TOP_BIT];
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign xrd_data_o = st_q.xrd_data;
	assign xrd_valid_o = st_q.xrd_valid;
	assign xrd_ea_o = st_q.xrd_ea;
	assign xrd_psv_o = st_q.xrd_psv;
	assign yrd_data_o = st_q.yrd_data;
	assign yrd_valid_o = st_q.yrd_valid;
	assign yrd_ea_o = st_q.yrd_ea;
	assign yrd_err_o = st_q.yrd_err;
	assign wr_ea_o = st_q.wr_ea;
	assign wr_done_o = st_q.wr_done;
	assign wr_psv_o = st_q.wr_psv;
endmodule : dds_access

/* tb/dds_access_props.sv */
`timescale 1ns/1ps
module dds_access_props #(
	parameter int IMPL_BYTES = 1024
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic xrd_en_i,
	input wire logic xrd_byte_i,
	input wire logic xrd_dual_i,
	input wire logic yrd_en_i,
	input wire logic wr_en_i,
	input wire logic [15:0] xrd_data_o,
	input wire logic xrd_valid_o,
	input wire logic [15:0] xrd_ea_o,
	input wire logic xrd_psv_o,
	input wire logic [15:0] yrd_data_o,
	input wire logic yrd_valid_o,
	input wire logic [15:0] yrd_ea_o,
	input wire logic yrd_err_o,
	input wire logic wr_done_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	property p_xans;
		xrd_en_i |=> xrd_valid_o;
	endproperty
	a_xans: assert property (p_xans) else $error("x read unanswered");
	property p_ylone;
		yrd_en_i && !(xrd_en_i && xrd_dual_i) |=> yrd_err_o && yrd_data_o == 16'h0000;
	endproperty
	a_ylone: assert property (p_ylone) else $error("lone y read");
	property p_wans;
		wr_en_i |=> wr_done_o;
	endproperty
	a_wans: assert property (p_wans) else $error("write unanswered");
	property p_psv;
		xrd_valid_o |-> xrd_psv_o == xrd_ea_o[15];
	endproperty
	a_psv: assert property (p_psv) else $error("psv flag wrong");
	property p_zero;
		xrd_valid_o && xrd_ea_o >= IMPL_BYTES |-> xrd_data_o == 16'h0000;
	endproperty
	a_zero: assert property (p_zero) else $error("outside read not 0");
	property p_byte;
		xrd_en_i && xrd_byte_i |=> xrd_data_o[15:8] == 8'h00;
	endproperty
	a_byte: assert property (p_byte) else $error("byte read high lane");
	property p_same;
		xrd_valid_o && yrd_valid_o && !yrd_err_o && !$past(xrd_byte_i)
			&& xrd_ea_o[15:1] == yrd_ea_o[15:1] |-> xrd_data_o == yrd_data_o;
	endproperty
	a_same: assert property (p_same) else $error("same word differs");
	property p_yreg;
		yrd_valid_o && yrd_ea_o < dds_pkg::XY_BOUNDARY |-> yrd_err_o;
	endproperty
	a_yreg: assert property (p_yreg) else $error("y read in x region");
endmodule : dds_access_props

/* tb/dds_core_model.sv */
`timescale 1ns/1ps
module dds_core_model (
	input wire logic mclk_i,
	output logic xrd_en_o,
	output logic xrd_byte_o,
	output logic xrd_dual_o,
	output logic [15:0] xrd_base_o,
	output logic [15:0] xrd_off_o,
	output dds_pkg::dds_mode_t xrd_mode_o,
	output logic yrd_en_o,
	output logic [15:0] yrd_base_o,
	output logic [15:0] yrd_off_o,
	output dds_pkg::dds_mode_t yrd_mode_o,
	output logic wr_en_o,
	output logic wr_byte_o,
	output logic [15:0] wr_base_o,
	output logic [15:0] wr_off_o,
	output dds_pkg::dds_mode_t wr_mode_o,
	output logic [15:0] wr_data_o
);
	initial
	begin
		{xrd_en_o, xrd_byte_o, xrd_dual_o, yrd_en_o, wr_en_o, wr_byte_o} = 6'h00;
		{xrd_base_o, xrd_off_o, yrd_base_o, yrd_off_o} = 64'h0;
		{wr_base_o, wr_off_o, wr_data_o} = 48'h0;
		xrd_mode_o = dds_pkg::DDS_MODE_LINEAR;
		yrd_mode_o = dds_pkg::DDS_MODE_LINEAR;
		wr_mode_o = dds_pkg::DDS_MODE_LINEAR;
	end
	task automatic idle();
		@(negedge mclk_i);
		{xrd_en_o, yrd_en_o, wr_en_o} = 3'h0;
		// idle data lines toggle instead of holding
		wr_data_o = ~wr_data_o;
	endtask : idle
	task automatic wr(input logic [15:0] b, input logic [15:0] d,
		input logic byt = 1'b0, input logic [15:0] o = 16'h0000,
		input dds_pkg::dds_mode_t m = dds_pkg::DDS_MODE_LINEAR);
		@(negedge mclk_i);
		{xrd_en_o, yrd_en_o, wr_en_o, wr_byte_o} = {3'h1, byt};
		{wr_base_o, wr_off_o, wr_data_o} = {b, o, d};
		wr_mode_o = m;
	endtask : wr
	task automatic rd(input logic [15:0] xb, input logic byt, input logic dual,
		input logic yen, input logic [15:0] yb, input logic [15:0] xo = 16'h0000,
		input logic [15:0] yo = 16'h0000,
		input dds_pkg::dds_mode_t m = dds_pkg::DDS_MODE_LINEAR);
		@(negedge mclk_i);
		{xrd_en_o, xrd_byte_o, xrd_dual_o, yrd_en_o, wr_en_o} = {1'b1, byt, dual, yen, 1'b0};
		{xrd_base_o, xrd_off_o, yrd_base_o, yrd_off_o} = {xb, xo, yb, yo};
		xrd_mode_o = m;
		yrd_mode_o = m;
	endtask : rd
endmodule : dds_core_model

/* tb/dual_data_space_access_test.sv */
`timescale 1ns/1ps
module dual_data_space_access_test;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [15:0] xmod_start_i = 16'h0100;
	logic [15:0] xmod_end_i = 16'h010f;
	logic [15:0] ymod_start_i = 16'h0200;
	logic [15:0] ymod_end_i = 16'h020f;
	logic [15:0] rev_mask_i = 16'h0010;
	logic xrd_en_i, xrd_byte_i, xrd_dual_i, yrd_en_i, wr_en_i, wr_byte_i;
	logic [15:0] xrd_base_i, xrd_off_i, yrd_base_i, yrd_off_i;
	logic [15:0] wr_base_i, wr_off_i, wr_data_i;
	dds_pkg::dds_mode_t xrd_mode_i, yrd_mode_i, wr_mode_i;
	logic [15:0] xrd_data_o, xrd_ea_o, yrd_data_o, yrd_ea_o, wr_ea_o;
	logic xrd_valid_o, xrd_psv_o, yrd_valid_o, yrd_err_o, wr_done_o, wr_psv_o;
	int err_count = 0;
	int compares = 0;

	always #10 mclk_i = ~mclk_i;

	dds_access #(.IMPL_BYTES(1024)) u_dut (
		.mclk_i, .rst_n_i, .xrd_en_i, .xrd_byte_i, .xrd_dual_i, .xrd_base_i,
		.xrd_off_i, .xrd_mode_i, .yrd_en_i, .yrd_base_i, .yrd_off_i,
		.yrd_mode_i, .wr_en_i, .wr_byte_i, .wr_base_i, .wr_off_i, .wr_mode_i,
		.wr_data_i, .xmod_start_i, .xmod_end_i, .ymod_start_i, .ymod_end_i,
		.rev_mask_i, .xrd_data_o, .xrd_valid_o, .xrd_ea_o, .xrd_psv_o,
		.yrd_data_o, .yrd_valid_o, .yrd_ea_o, .yrd_err_o, .wr_ea_o,
		.wr_done_o, .wr_psv_o
	);
	dds_core_model u_core (
		.mclk_i, .xrd_en_o(xrd_en_i), .xrd_byte_o(xrd_byte_i),
		.xrd_dual_o(xrd_dual_i), .xrd_base_o(xrd_base_i),
		.xrd_off_o(xrd_off_i), .xrd_mode_o(xrd_mode_i), .yrd_en_o(yrd_en_i),
		.yrd_base_o(yrd_base_i), .yrd_off_o(yrd_off_i),
		.yrd_mode_o(yrd_mode_i), .wr_en_o(wr_en_i), .wr_byte_o(wr_byte_i),
		.wr_base_o(wr_base_i), .wr_off_o(wr_off_i), .wr_mode_o(wr_mode_i),
		.wr_data_o(wr_data_i)
	);

	task automatic go();
		@(posedge mclk_i);
		#1;
	endtask : go
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		compares++;
		if (g !== e)
		begin
			$display("[ERR] %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask : chk
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	task automatic t_lanes();
		u_core.wr(16'h0010, 16'habcd);
		go();
		chk("wr_done", 16'h0001, {15'h0, wr_done_o});
		chk("wr_ea", 16'h0010, wr_ea_o);
		u_core.wr(16'h0013, 16'h005a, 1'b1);
		go();
		u_core.rd(16'h0012, 1'b0, 1'b0, 1'b0, 16'h0000);
		go();
		chk("word", 16'h5a00, xrd_data_o);
		u_core.rd(16'h0011, 1'b1, 1'b0, 1'b0, 16'h0000);
		go();
		chk("byte odd", 16'h00ab, xrd_data_o);
		u_core.idle();
		go();
		chk("x valid", 16'h0000, {15'h0, xrd_valid_o});
		$display("lanes test done");
	endtask : t_lanes
	task automatic t_space();
		u_core.wr(16'h0400, 16'h1234);
		go();
		u_core.wr(16'h8000, 16'h1234);
		go();
		chk("wr_psv", 16'h0001, {15'h0, wr_psv_o});
		u_core.rd(16'h0400, 1'b0, 1'b0, 1'b0, 16'h0000);
		go();
		chk("outside", 16'h0000, xrd_data_o);
		u_core.rd(16'h8000, 1'b1, 1'b0, 1'b0, 16'h0000);
		go();
		chk("psv", 16'h0001, {15'h0, xrd_psv_o});
		u_core.idle();
		$display("space test done");
	endtask : t_space
	task automatic t_dual();
		u_core.wr(16'h0200, 16'h1111);
		go();
		u_core.rd(16'h0010, 1'b0, 1'b1, 1'b1, 16'h0200);
		go();
		chk("x pair", 16'habcd, xrd_data_o);
		chk("y pair", 16'h1111, yrd_data_o);
		chk("y err", 16'h0000, {15'h0, yrd_err_o});
		u_core.rd(16'h0200, 1'b0, 1'b1, 1'b1, 16'h0200);
		go();
		chk("same x", 16'h1111, xrd_data_o);
		chk("same y", 16'h1111, yrd_data_o);
		u_core.rd(16'h0010, 1'b0, 1'b0, 1'b1, 16'h0200);
		go();
		chk("lone y", 16'h0001, {15'h0, yrd_err_o});
		u_core.rd(16'h0010, 1'b0, 1'b1, 1'b1, 16'h0010);
		go();
		chk("y in x", 16'h0001, {15'h0, yrd_err_o});
		u_core.idle();
		$display("dual test done");
	endtask : t_dual
	task automatic t_addr();
		u_core.wr(16'h010e, 16'h7777, 1'b0, 16'h0004, dds_pkg::DDS_MODE_MODULO);
		go();
		chk("wr mod", 16'h0102, wr_ea_o);
		u_core.rd(16'h0100, 1'b0, 1'b1, 1'b1, 16'h020e, 16'hfffe, 16'h0004,
			dds_pkg::DDS_MODE_MODULO);
		go();
		chk("x mod", 16'h010e, xrd_ea_o);
		chk("y mod", 16'h0202, yrd_ea_o);
		u_core.wr(16'h0100, 16'h4444, 1'b0, 16'h0002, dds_pkg::DDS_MODE_BITREV);
		go();
		chk("wr rev", 16'h0110, wr_ea_o);
		u_core.rd(16'h0100, 1'b0, 1'b1, 1'b1, 16'h0200, 16'h0002, 16'h0002,
			dds_pkg::DDS_MODE_BITREV);
		go();
		chk("x rev", 16'h0102, xrd_ea_o);
		chk("y rev", 16'h0202, yrd_ea_o);
		u_core.wr(16'h0300, 16'h4444, 1'b0, 16'h0002, dds_pkg::DDS_MODE_BITREV);
		go();
		chk("rev in y", 16'h0302, wr_ea_o);
		u_core.idle();
		$display("address test done");
	endtask : t_addr

	initial
	begin
		repeat (6) @(posedge mclk_i);
		@(negedge mclk_i);
		rst_n_i = 1'b1;
		t_lanes();
		t_space();
		t_dual();
		t_addr();
		wrap_up();
	end
	// tests need well under 100 cycles
	initial
	begin
		#20us;
		err_count++;
		wrap_up();
	end
endmodule : dual_data_space_access_test

bind dds_access dds_access_props #(.IMPL_BYTES(IMPL_BYTES)) u_props (
	.mclk_i, .rst_n_i, .xrd_en_i, .xrd_byte_i, .xrd_dual_i, .yrd_en_i,
	.wr_en_i, .xrd_data_o, .xrd_valid_o, .xrd_ea_o, .xrd_psv_o, .yrd_data_o,
	.yrd_valid_o, .yrd_ea_o, .yrd_err_o, .wr_done_o
);
